// *** qr_host.sv ***
// Purpose: host side of the serial quick read
// Assumes: mode 0, SCLK period of 10 CLK
// Notes: SDI flips when idle so no stale bit shows
`timescale 1ns/1ns
module qr_host (
   // pins
   input wire logic CLK,
   input wire logic SDO,
   output logic SCLK,
   output logic SEL_N,
   output logic SDI
);
   ////////////////////////////////////////////////////////////
   // idle: clock low, deselected
   initial begin
      {SCLK, SEL_N, SDI} = 3'b010;
   end
   // one frame: command byte out, data byte in
   task automatic xfer(logic [7:0] c, output logic [7:0] d);
      SEL_N <= 0;
      for (int i = 0; i < 16; i++) begin
         SDI <= i < 8 ? c[7-i] : ~SDI;
         repeat (5) @(posedge CLK);
         SCLK <= 1;
         if (i > 7) d[15-i] = SDO;
         repeat (5) @(posedge CLK);
         SCLK <= 0;
      end
      repeat (5) @(posedge CLK);
      SEL_N <= 1;
      SDI <= ~SDI;
      // deselect long enough for the frame to reset
      repeat (5) @(posedge CLK);
   endtask
endmodule

// *** rssi_mon_pkg.sv ***
// Purpose: shared constants and types for the strength monitor
// Assumes: 125 MHz system clock, 32-bit APB register port
// Notes: times are kept in their own units, cycle counts derive from them
package rssi_mon_pkg;
   // clock and timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int QUERY_TIME_US = 33; // status query to completion
   localparam int QUERY_CYC = QUERY_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int CAL_FIRST_MS = 250; // first image calibration
   localparam int CAL_FIRST_CYC = CAL_FIRST_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CAL_RE_MS = 100; // later recalibrations
   localparam int CAL_RE_CYC = CAL_RE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int AGC_MAX_NS = 2000; // gain loop must settle below this
   localparam int AGC_CYC = (AGC_MAX_NS - 1) / CLK_PERIOD_NS;
   // register byte offsets
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_THRESH = 8'h04;
   localparam logic [7:0] OFS_OFFSET = 8'h08;
   localparam logic [7:0] OFS_JUMP = 8'h0C;
   localparam logic [7:0] OFS_QRSEL = 8'h10;
   localparam logic [7:0] OFS_GPSEL = 8'h14;
   localparam logic [7:0] OFS_CMD = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_QRES = 8'h20;
   localparam logic [7:0] OFS_IFBW = 8'h24;
   // reset values
   localparam logic [7:0] OFFSET_RST = 8'h40;
   localparam logic [7:0] THRESH_RST = 8'hFF;
   localparam logic [7:0] JUMP_RST = 8'h0C;
   // status flag positions (write one to clear)
   localparam int ST_JUMP_UP = 18;
   localparam int ST_JUMP_DN = 19;
   // latch event choices and limits
   localparam logic [1:0] LATCH_PRE = 2'h0;
   localparam logic [1:0] LATCH_SYNC = 2'h1;
   localparam logic [1:0] LATCH_CNT = 2'h2;
   localparam logic [7:0] LATCH_MIN_BITS = 8'h04;
   localparam logic [7:0] LATCH_MIN_AVG = 8'h07;
   localparam logic [1:0] AVG_LAST = 2'h3; // fourth bit of a block
   // frequency correction range in percent of IF bandwidth
   localparam logic [21:0] AFC_PCT_MODEM = 22'h000019; // 25 %
   localparam logic [21:0] AFC_PCT_PLL = 22'h000023; // 35 %
   localparam logic [21:0] PCT_DIV = 22'h000064; // 100
   // command codes
   localparam logic [7:0] CMD_STATUS_QUERY = 8'h20;
   localparam logic [7:0] CMD_IMAGE_CAL = 8'h17;
   localparam logic [7:0] QR_CMD_BASE = 8'h50; // serial quick read A..D
   // quick read sources
   localparam logic [1:0] QS_CUR = 2'h0;
   localparam logic [1:0] QS_LATCHED = 2'h1;
   localparam logic [1:0] QS_FLAGS = 2'h2;
   // general-purpose pin sources
   localparam logic [2:0] GS_LOW = 3'h0;
   localparam logic [2:0] GS_THRESH = 3'h1;
   localparam logic [2:0] GS_THRESH_L = 3'h2;
   localparam logic [2:0] GS_JUMP = 3'h3;
   localparam logic [2:0] GS_CAL = 3'h4;
   localparam logic [2:0] GS_DONE = 3'h5;
   // configuration word, bit 0 is avg_en
   typedef struct packed {
      logic afc_en;
      logic [2:0] jump_gap;
      logic jump_restart;
      logic jump_dn;
      logic jump_up;
      logic [7:0] latch_count;
      logic [1:0] latch_sel;
      logic avg_en;
   } cfg_t;
   // command sequencer states
   typedef enum logic [1:0] {CMD_IDLE, CMD_QUERY, CMD_CAL} cmd_state_t;
endpackage

// *** rx_signal_strength_monitor.sv ***
// Purpose: receive signal-strength monitor with APB registers
// Assumes: FILT_PWR is post-filter power in half-dB code, same clock
// Notes: serial quick-read pins are sampled through two flip-flops
// How it works
// - strength code steps half a decibel
// - measure power after the channel filter
// - gain loop settles within bit or 2us
// - correction range 0.25 or 0.35 IF bandwidth
// - image calibration 250 ms first, 100 ms after
// - quick read registers answer in 16 clocks
// - latch strength once per packet after entry
// - status query completes 33 us later
// - latch on preamble, sync or bit count
// - update per bit or four-bit average
// - averaged latch not before seven bits
// - latched value clears on receive entry
// - flag when current strength exceeds threshold
// - latched and live compare on any pin
// - jump up and down enabled separately
// - jump when change reaches programmed size
// - compare levels a programmed interval apart
// - optional receiver restart on jump
`timescale 1ns/1ns
module rx_signal_strength_monitor
   import rssi_mon_pkg::*;
#(
   parameter int QUERY_CYCLES = QUERY_CYC,
   parameter int CAL_FIRST_CYCLES = CAL_FIRST_CYC,
   parameter int CAL_RE_CYCLES = CAL_RE_CYC,
   parameter int JUMP_DEPTH = 8,
   parameter int GPIO_N = 4
) (
   // system
   input wire logic CLK,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // modem side
   input wire logic [7:0] FILT_PWR,
   input wire logic BIT_TICK,
   input wire logic RX_ENTER,
   input wire logic PREAMBLE_DET,
   input wire logic SYNC_DET,
   input wire logic PEAK_TRIP,
   input wire logic [15:0] FREQ_ERR,
   // modem controls
   output logic RX_RESTART,
   output logic AGC_BUSY,
   output logic GAIN_APPLY,
   output logic [15:0] FREQ_CORR,
   output logic CAL_BUSY,
   output logic [GPIO_N-1:0] GPIO,
   // serial quick read
   input wire logic SCLK,
   input wire logic SEL_N,
   input wire logic SDI,
   output logic SDO
);
   ////////////////////////////////////////////////////////////////////////
   // register storage
   cfg_t cfg; // strength_config_property
   logic [7:0] thresh; // strength_threshold_property
   logic [7:0] offset_cfg; // strength_offset_property, host math only
   logic [7:0] jump_size; // jump_size_property
   logic [7:0] qr_sel; // two bits per quick read register
   logic [11:0] gpio_sel; // three bits per pin
   logic [15:0] ifbw; // IF bandwidth for correction range
   logic apb_wr; // write access phase
   logic apb_setup; // setup phase, read data is prepared here
   logic mapped; // address decodes to a register
   logic [31:0] status; // assembled status word
   logic [31:0] next_rdata; // read mux

   assign PREADY = 1'b1; // zero wait states
   assign apb_wr = PSEL & PENABLE & PWRITE;
   assign apb_setup = PSEL & ~PENABLE;

   // address decode
   always_comb begin
      case (PADDR)
         OFS_CFG, OFS_THRESH, OFS_OFFSET, OFS_JUMP, OFS_QRSEL, OFS_GPSEL,
         OFS_CMD, OFS_STATUS, OFS_QRES, OFS_IFBW: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // configuration writes
   always_ff @(posedge CLK) begin
      if (RST) begin
         cfg <= '0;
         thresh <= THRESH_RST;
         offset_cfg <= OFFSET_RST;
         jump_size <= JUMP_RST;
         qr_sel <= '0;
         gpio_sel <= '0;
         ifbw <= '0;
      end else if (apb_wr) begin
         case (PADDR)
            OFS_CFG: cfg <= PWDATA[$bits(cfg_t)-1:0];
            OFS_THRESH: thresh <= PWDATA[7:0];
            OFS_OFFSET: offset_cfg <= PWDATA[7:0];
            OFS_JUMP: jump_size <= PWDATA[7:0];
            OFS_QRSEL: qr_sel <= PWDATA[7:0];
            OFS_GPSEL: gpio_sel <= PWDATA[11:0];
            OFS_IFBW: ifbw <= PWDATA[15:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strength update, per bit or four-bit average
   logic [7:0] cur; // current strength, half-dB code
   logic upd; // one cycle, cur just changed
   logic [9:0] acc; // average accumulator
   logic [1:0] avg_ph; // position inside four-bit block
   logic [9:0] next_sum;

   assign next_sum = acc + {2'h0, FILT_PWR};

   // sample filtered power on each bit tick
   always_ff @(posedge CLK) begin
      if (RST || RX_ENTER) begin
         cur <= '0;
         upd <= 1'b0;
         acc <= '0;
         avg_ph <= '0;
      end else begin
         upd <= 1'b0;
         if (BIT_TICK && !cfg.avg_en) begin
            cur <= FILT_PWR;
            upd <= 1'b1;
         end else if (BIT_TICK) begin
            avg_ph <= avg_ph + 2'h1;
            acc <= next_sum;
            if (avg_ph == AVG_LAST) begin
               cur <= next_sum[9:2];
               acc <= '0;
               upd <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-packet latch
   logic [7:0] bit_cnt; // bits since receive start, saturating
   logic [7:0] latched; // latched strength
   logic lat_pend; // latch event seen, waiting for minimum
   logic lat_done; // latched for this packet
   logic lat_trig; // selected event this cycle
   logic [7:0] min_bits; // earliest latch bit
   logic [7:0] eff_count; // bit-count event, never below four

   assign min_bits = cfg.avg_en ? LATCH_MIN_AVG : LATCH_MIN_BITS;
   assign eff_count = (cfg.latch_count < LATCH_MIN_BITS) ?
                      LATCH_MIN_BITS : cfg.latch_count;

   // latch event selection
   always_comb begin
      case (cfg.latch_sel)
         LATCH_PRE: lat_trig = PREAMBLE_DET;
         LATCH_SYNC: lat_trig = SYNC_DET;
         LATCH_CNT: lat_trig = bit_cnt >= eff_count;
         default: lat_trig = 1'b0;
      endcase
   end

   // bit counter from receive start
   always_ff @(posedge CLK) begin
      if (RST || RX_ENTER) begin
         bit_cnt <= '0;
      end else if (BIT_TICK && bit_cnt != 8'hFF) begin
         bit_cnt <= bit_cnt + 8'h01;
      end
   end

   // capture once, deferred to the minimum bit count
   always_ff @(posedge CLK) begin
      if (RST || RX_ENTER) begin
         latched <= '0;
         lat_pend <= 1'b0;
         lat_done <= 1'b0;
      end else if (!lat_done) begin
         lat_pend <= lat_pend | lat_trig;
         if ((lat_pend || lat_trig) && bit_cnt >= min_bits) begin
            latched <= cur;
            lat_done <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // threshold compare
   logic thr_now; // live compare result
   logic thr_lat; // sticky until next receive entry

   always_ff @(posedge CLK) begin
      if (RST || RX_ENTER) begin
         thr_now <= 1'b0;
         thr_lat <= 1'b0;
      end else if (upd) begin
         thr_now <= cur > thresh;
         thr_lat <= thr_lat | (cur > thresh);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // jump detection over a programmed update interval
   logic [7:0] hist [JUMP_DEPTH]; // past strength values
   logic [3:0] fill; // valid history entries
   logic [7:0] old; // value jump_gap+1 updates back
   logic hist_ok; // enough history for the interval
   logic hit_up;
   logic hit_dn;
   logic flag_up; // sticky, write one to clear
   logic flag_dn;
   logic clr_wr; // status write this cycle

   assign old = hist[cfg.jump_gap];
   assign hist_ok = fill > {1'b0, cfg.jump_gap};
   assign hit_up = upd & hist_ok & cfg.jump_up & (cur > old) &
                   ((cur - old) >= jump_size);
   assign hit_dn = upd & hist_ok & cfg.jump_dn & (old > cur) &
                   ((old - cur) >= jump_size);
   assign clr_wr = apb_wr && PADDR == OFS_STATUS;

   // history shift register
   generate
      for (genvar i = 0; i < JUMP_DEPTH; i++) begin : g_hist
         always_ff @(posedge CLK) begin
            if (RST || RX_ENTER || RX_RESTART) begin
               hist[i] <= '0;
            end else if (upd) begin
               hist[i] <= (i == 0) ? cur : hist[(i == 0) ? 0 : i - 1];
            end
         end
      end
   endgenerate

   // history fill level
   always_ff @(posedge CLK) begin
      if (RST || RX_ENTER || RX_RESTART) begin
         fill <= '0;
      end else if (upd && fill <= 4'(JUMP_DEPTH - 1)) begin
         fill <= fill + 4'h1;
      end
   end

   // sticky jump flags, a new hit beats the clear
   always_ff @(posedge CLK) begin
      if (RST) begin
         flag_up <= 1'b0;
         flag_dn <= 1'b0;
      end else begin
         flag_up <= hit_up | (flag_up & ~(clr_wr & PWDATA[ST_JUMP_UP]));
         flag_dn <= hit_dn | (flag_dn & ~(clr_wr & PWDATA[ST_JUMP_DN]));
      end
   end

   // receiver restart pulse
   always_ff @(posedge CLK) begin
      if (RST) begin
         RX_RESTART <= 1'b0;
      end else begin
         RX_RESTART <= (hit_up | hit_dn) & cfg.jump_restart;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // gain loop settle timer
   logic [7:0] agc_cnt;

   always_ff @(posedge CLK) begin
      if (RST) begin
         AGC_BUSY <= 1'b0;
         GAIN_APPLY <= 1'b0;
         agc_cnt <= '0;
      end else begin
         GAIN_APPLY <= 1'b0;
         if (!AGC_BUSY && (PEAK_TRIP || RX_ENTER)) begin
            AGC_BUSY <= 1'b1;
            agc_cnt <= '0;
         end else if (AGC_BUSY) begin
            agc_cnt <= agc_cnt + 8'h01;
            if (BIT_TICK || agc_cnt == 8'(AGC_CYC - 1)) begin
               AGC_BUSY <= 1'b0;
               GAIN_APPLY <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // frequency correction clamp
   logic [21:0] prod; // bandwidth times percentage
   logic [21:0] lim22;
   logic signed [16:0] lim; // allowed offset magnitude
   logic signed [16:0] err;

   assign prod = {6'h00, ifbw} * (cfg.afc_en ? AFC_PCT_PLL : AFC_PCT_MODEM);
   assign lim22 = prod / PCT_DIV;
   assign lim = $signed({1'b0, lim22[15:0]});
   assign err = $signed({FREQ_ERR[15], FREQ_ERR});

   always_ff @(posedge CLK) begin
      if (RST) begin
         FREQ_CORR <= '0;
      end else if (err > lim) begin
         FREQ_CORR <= lim[15:0];
      end else if (err < -lim) begin
         FREQ_CORR <= 16'(-lim);
      end else begin
         FREQ_CORR <= err[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer: status query and image calibration
   cmd_state_t state;
   logic [31:0] cmd_cnt; // remaining cycles
   logic cmd_done; // completion flag
   logic cal_once; // a first calibration has been started
   logic [7:0] q_cur; // query snapshot, current
   logic [7:0] q_lat; // query snapshot, latched
   logic cmd_wr;

   assign cmd_wr = apb_wr && PADDR == OFS_CMD;
   assign CAL_BUSY = state == CMD_CAL;

   always_ff @(posedge CLK) begin
      if (RST) begin
         state <= CMD_IDLE;
         cmd_cnt <= '0;
         cmd_done <= 1'b1;
         cal_once <= 1'b0;
         q_cur <= '0;
         q_lat <= '0;
      end else begin
         case (state)
            CMD_IDLE: begin
               if (cmd_wr && PWDATA[7:0] == CMD_STATUS_QUERY) begin
                  q_cur <= cur;
                  q_lat <= latched;
                  cmd_cnt <= 32'(QUERY_CYCLES - 1);
                  cmd_done <= 1'b0;
                  state <= CMD_QUERY;
               end else if (cmd_wr && PWDATA[7:0] == CMD_IMAGE_CAL) begin
                  cmd_cnt <= cal_once ? 32'(CAL_RE_CYCLES - 1) :
                                        32'(CAL_FIRST_CYCLES - 1);
                  cal_once <= 1'b1;
                  cmd_done <= 1'b0;
                  state <= CMD_CAL;
               end
            end
            CMD_QUERY, CMD_CAL: begin
               if (cmd_cnt == '0) begin
                  cmd_done <= 1'b1;
                  state <= CMD_IDLE;
               end else begin
                  cmd_cnt <= cmd_cnt - 32'h1;
               end
            end
            default: state <= CMD_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, prepared in the setup phase
   assign status = {10'h000, CAL_BUSY, AGC_BUSY, flag_dn, flag_up, thr_lat,
                    thr_now, latched, cur};

   always_comb begin
      case (PADDR)
         OFS_CFG: next_rdata = 32'(cfg);
         OFS_THRESH: next_rdata = {24'h0, thresh};
         OFS_OFFSET: next_rdata = {24'h0, offset_cfg};
         OFS_JUMP: next_rdata = {24'h0, jump_size};
         OFS_QRSEL: next_rdata = {24'h0, qr_sel};
         OFS_GPSEL: next_rdata = {20'h0, gpio_sel};
         OFS_CMD: next_rdata = {31'h0, cmd_done};
         OFS_STATUS: next_rdata = status;
         OFS_QRES: next_rdata = {16'h0, q_lat, q_cur};
         OFS_IFBW: next_rdata = {16'h0, ifbw};
         default: next_rdata = 32'h0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else if (apb_setup) begin
         PRDATA <= PWRITE ? 32'h0 : next_rdata;
         PSLVERR <= ~mapped;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general-purpose pin routing
   generate
      for (genvar p = 0; p < GPIO_N; p++) begin : g_pin
         always_ff @(posedge CLK) begin
            if (RST) begin
               GPIO[p] <= 1'b0;
            end else begin
               case (gpio_sel[3*p +: 3])
                  GS_THRESH: GPIO[p] <= thr_now;
                  GS_THRESH_L: GPIO[p] <= thr_lat;
                  GS_JUMP: GPIO[p] <= flag_up | flag_dn;
                  GS_CAL: GPIO[p] <= CAL_BUSY;
                  GS_DONE: GPIO[p] <= cmd_done;
                  default: GPIO[p] <= 1'b0;
               endcase
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // serial quick read: 8 command clocks then 8 data clocks
   logic [2:0] sclk_s; // synchroniser then edge history
   logic [1:0] sel_s;
   logic [1:0] sdi_s;
   logic sclk_rise;
   logic sclk_fall;
   logic [4:0] sbit; // serial clocks counted in this frame
   logic [7:0] scmd; // received command byte
   logic [7:0] stx; // outgoing data
   logic [7:0] next_cmd;
   logic [1:0] qsrc; // selected source of addressed register

   assign sclk_rise = sclk_s[1] & ~sclk_s[2];
   assign sclk_fall = ~sclk_s[1] & sclk_s[2];
   assign next_cmd = {scmd[6:0], sdi_s[1]};
   assign qsrc = qr_sel[2*next_cmd[1:0] +: 2];

   // pin synchronisers
   always_ff @(posedge CLK) begin
      if (RST) begin
         sclk_s <= '0;
         sel_s <= 2'h3;
         sdi_s <= '0;
      end else begin
         sclk_s <= {sclk_s[1:0], SCLK};
         sel_s <= {sel_s[0], SEL_N};
         sdi_s <= {sdi_s[0], SDI};
      end
   end

   // shift engine, no command completion wait
   always_ff @(posedge CLK) begin
      if (RST || sel_s[1]) begin
         sbit <= '0;
         scmd <= '0;
         stx <= '0;
         SDO <= 1'b0;
      end else if (sclk_rise && sbit < 5'h10) begin
         sbit <= sbit + 5'h01;
         if (sbit < 5'h08) begin
            scmd <= next_cmd;
         end
         if (sbit == 5'h07) begin
            if (next_cmd[7:2] != QR_CMD_BASE[7:2]) begin
               stx <= '0;
            end else begin
               case (qsrc)
                  QS_CUR: stx <= cur;
                  QS_LATCHED: stx <= latched;
                  QS_FLAGS: stx <= status[23:16];
                  default: stx <= '0;
               endcase
            end
         end
      end else if (sclk_fall && sbit >= 5'h08) begin
         SDO <= stx[7];
         stx <= {stx[6:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence jump_seen;
      (hit_up || hit_dn) && cfg.jump_restart;
   endsequence
   sequence restart_out;
      ##1 RX_RESTART;
   endsequence

   latch_clear_a: assert property (@(posedge CLK) disable iff (RST)
      RX_ENTER |=> latched == 8'h00 && !lat_done)
      else $error("latched value not cleared on receive entry");
   latch_min_a: assert property (@(posedge CLK) disable iff (RST)
      $rose(lat_done) |-> $past(bit_cnt) >= $past(min_bits))
      else $error("strength latched too early");
   latch_once_a: assert property (@(posedge CLK) disable iff (RST)
      lat_done && !RX_ENTER |=> $stable(latched))
      else $error("latched value changed twice in a packet");
   jump_restart_a: assert property (@(posedge CLK) disable iff (RST)
      jump_seen |-> restart_out)
      else $error("no restart after jump");
   avg_rate_a: assert property (@(posedge CLK) disable iff (RST)
      upd && cfg.avg_en && !$past(RX_ENTER) |-> $past(avg_ph) == AVG_LAST)
      else $error("averaged update off its four-bit block");
   thresh_cmp_a: assert property (@(posedge CLK) disable iff (RST)
      upd && !RX_ENTER && $stable(thresh) ##1 !RX_ENTER
      |-> thr_now == ($past(cur) > thresh))
      else $error("threshold result wrong");
   agc_bound_a: assert property (@(posedge CLK) disable iff (RST)
      AGC_BUSY |-> agc_cnt < 8'(AGC_CYC))
      else $error("gain loop ran past its limit");
   query_time_a: assert property (@(posedge CLK) disable iff (RST)
      state == CMD_IDLE && cmd_wr && PWDATA[7:0] == CMD_STATUS_QUERY
      |=> !cmd_done && cmd_cnt == 32'(QUERY_CYCLES - 1))
      else $error("status query timer not loaded");
   afc_range_a: assert property (@(posedge CLK) disable iff (RST)
      ##1 $stable(lim) |-> $signed({FREQ_CORR[15], FREQ_CORR}) <= lim)
      else $error("frequency correction beyond range");
endmodule

// *** tb_rx_signal_strength_monitor.sv ***
// Purpose: self-checking bench for the strength monitor
// Assumes: shortened query and calibration counts
// Notes: rows hold a power code and the threshold flag it gives
`timescale 1ns/1ns
module tb_rx_signal_strength_monitor
   import rssi_mon_pkg::*;
;
   logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BIT_TICK;
   logic RX_ENTER, PREAMBLE_DET, SYNC_DET, PEAK_TRIP, RX_RESTART;
   logic AGC_BUSY, GAIN_APPLY, CAL_BUSY, SCLK, SEL_N, SDI, SDO;
   logic [7:0] PADDR, FILT_PWR, q;
   logic [15:0] FREQ_ERR, FREQ_CORR;
   logic [31:0] PWDATA, PRDATA, r;
   logic [3:0] GPIO;
   logic err, saw;
   int bad_count, n_compared, cyc, k, n;
   logic [8:0] rows [4] = '{9'h010, 9'h060, 9'h161, 9'h1FE};
   rx_signal_strength_monitor #(.QUERY_CYCLES(20),
      .CAL_FIRST_CYCLES(50), .CAL_RE_CYCLES(30)) dut_u (.*);
   qr_host host_u (.*);
   ////////////////////////////////////////////////////////////
   // clock
   initial begin
      CLK = 0;
      forever #4 CLK = ~CLK;
   end
   // hang ceiling and restart catcher
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (RX_RESTART === 1'b1) saw <= 1;
      if (cyc == 6000) begin
         bad_count++;
         end_of_test;
      end
   end
   task automatic chk(logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // one apb transfer, result in r and err
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge CLK);
      PSEL <= 1;
      PENABLE <= 0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK) PENABLE <= 1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      r = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task automatic tick(int n);
      repeat (n) begin
         BIT_TICK <= 1;
         @(posedge CLK) BIT_TICK <= 0;
         repeat (3) @(posedge CLK);
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {PSEL, PENABLE, PWRITE, BIT_TICK, RX_ENTER, saw} = '0;
      {PREAMBLE_DET, SYNC_DET, PEAK_TRIP} = '0;
      {PADDR, PWDATA, FILT_PWR, FREQ_ERR} = '0;
      RST = 1;
      repeat (5) @(posedge CLK);
      RST <= 0;
      apb(1, OFS_OFFSET, 32'h40);
      apb(1, OFS_THRESH, 32'h60);
      apb(1, OFS_GPSEL, GS_THRESH);
      foreach (rows[i]) begin
         FILT_PWR <= rows[i][7:0];
         tick(1);
         apb(0, OFS_STATUS, 0);
         chk(r[7:0], rows[i][7:0]);
         chk(r[16], rows[i][8]);
         chk(GPIO[0], rows[i][8]);
      end
      // reset values, unmapped address
      RST <= 1;
      @(posedge CLK) RST <= 0;
      apb(0, OFS_THRESH, 0);
      chk(r, THRESH_RST);
      apb(0, OFS_JUMP, 0);
      chk(r, JUMP_RST);
      apb(0, OFS_OFFSET, 0);
      chk(r, OFFSET_RST);
      apb(0, 8'h40, 0);
      chk(err, 1);
      // latch clears on entry, waits for bit count
      FILT_PWR <= 8'h70;
      for (k = 0; k < 2; k++) begin
         apb(1, OFS_CFG, 32'h24 | k);
         RX_ENTER <= 1;
         @(posedge CLK) RX_ENTER <= 0;
         apb(0, OFS_STATUS, 0);
         chk(r[15:8], 0);
         tick(3 + 3 * k);
         apb(0, OFS_STATUS, 0);
         chk(r[15:8], 0);
         tick(1 + k);
         apb(0, OFS_STATUS, 0);
         chk(r[15:8], 8'h70);
      end
      // status query: wait for done, then snapshot
      apb(1, OFS_CMD, CMD_STATUS_QUERY);
      k = 0;
      do begin
         apb(0, OFS_CMD, 0);
         k++;
      end while (r[0] !== 1'b1 && k < 40);
      chk(k > 7 && k < 14, 1);
      apb(0, OFS_QRES, 0);
      chk(r[15:0], 16'h7070);
      // image calibration, first then rerun
      for (int j = 0; j < 2; j++) begin
         apb(1, OFS_CMD, CMD_IMAGE_CAL);
         k = 0;
         repeat (80) @(posedge CLK) k += CAL_BUSY;
         chk(k, j ? 30 : 50);
      end
      // gain loop with no bit tick ends on its limit
      PEAK_TRIP <= 1;
      @(posedge CLK) PEAK_TRIP <= 0;
      k = 0;
      n = 0;
      repeat (260) @(posedge CLK) begin
         k += AGC_BUSY;
         n += GAIN_APPLY;
      end
      chk(k, AGC_CYC);
      chk(n, 1);
      // correction clamp without and with afc
      apb(1, OFS_IFBW, 32'h3E8);
      FREQ_ERR <= 16'h01F4;
      for (k = 0; k < 2; k++) begin
         apb(1, OFS_CFG, k << 17);
         repeat (2) @(posedge CLK);
         chk(FREQ_CORR, k ? 16'h015E : 16'h00FA);
      end
      // jump up with restart, jump down left off
      apb(1, OFS_CFG, 32'h2824);
      tick(2);
      FILT_PWR <= 8'h80;
      tick(1);
      apb(0, OFS_STATUS, 0);
      chk(r[18], 1);
      chk(saw, 1);
      tick(1);
      FILT_PWR <= 8'h70;
      tick(1);
      apb(0, OFS_STATUS, 0);
      chk(r[19], 0);
      // clear both flags, then down detection only
      apb(1, OFS_STATUS, 32'h000C0000);
      apb(0, OFS_STATUS, 0);
      chk(r[19:18], 0);
      apb(1, OFS_CFG, 32'h1024);
      FILT_PWR <= 8'h90;
      tick(1);
      FILT_PWR <= 8'h80;
      tick(1);
      apb(0, OFS_STATUS, 0);
      chk(r[19:18], 2'b10);
      // quick reads: latched, current, then a bad command
      apb(1, OFS_QRSEL, 32'h40);
      host_u.xfer(8'h53, q);
      chk(q, 8'h70);
      host_u.xfer(QR_CMD_BASE, q);
      chk(q, 8'h80);
      host_u.xfer(8'h54, q);
      chk(q, 0);
      // latch on preamble, then on sync, never on the other
      for (k = 0; k < 2; k++) begin
         apb(1, OFS_CFG, k << 1);
         RX_ENTER <= 1;
         @(posedge CLK) RX_ENTER <= 0;
         tick(5);
         {PREAMBLE_DET, SYNC_DET} <= k ? 2'b10 : 2'b01;
         @(posedge CLK) {PREAMBLE_DET, SYNC_DET} <= 2'b00;
         apb(0, OFS_STATUS, 0);
         chk(r[15:8], 0);
         {PREAMBLE_DET, SYNC_DET} <= k ? 2'b01 : 2'b10;
         @(posedge CLK) {PREAMBLE_DET, SYNC_DET} <= 2'b00;
         apb(0, OFS_STATUS, 0);
         chk(r[15:8], 8'h80);
      end
      end_of_test;
   end
endmodule
